// >>> src/sqm_cfg.svh
// Register offsets, field positions and reset values for the switch config
`ifndef SQM_CFG_SVH
`define SQM_CFG_SVH

`define SQM_IDX_MAP_3A 12'h35D
`define SQM_IDX_MAP_3C 12'h35E
`define SQM_IDX_MAP_3E 12'h35F
`define SQM_IDX_MIRSNP 12'h370
`define SQM_IDX_COLOR 12'h378
`define SQM_IDX_EVT 12'h37C
`define SQM_IDX_NEVT 12'h37D

`define SQM_MAP_WMASK 8'h77
`define SQM_MAP_RST 8'h00
`define SQM_MIRSNP_WMASK 8'h4D
`define SQM_MIRSNP_RST 8'h00
`define SQM_COLOR_WMASK 8'h3F
`define SQM_COLOR_RST 8'h39
`define SQM_PRIO_WMASK 8'h8F
`define SQM_PRIO_RST 8'h0F

`define SQM_BIT_V4SNOOP 6
`define SQM_BIT_CRIT 3
`define SQM_BIT_V6SNOOP 2
`define SQM_BIT_MATCH 0
`define SQM_BIT_OVR 7

`define SQM_NH_HOPBYHOP 8'h00
`define SQM_NH_ICMPV4 8'h01
`define SQM_NH_ICMPV6 8'h3A
`define SQM_NH_ROUTE 8'h2B
`define SQM_NH_FRAG 8'h2C
`define SQM_NH_ESP 8'h32
`define SQM_NH_AUTH 8'h33
`define SQM_NH_DSTOPT 8'h3C

`endif

// >>> src/sqm_pkg.sv
// Types shared by the switch config register bank
package sqm_pkg;
  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } sqm_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } sqm_apb_rsp_t;

  typedef struct packed {
    logic mirror_both_match;
    logic [3:0] event_prio;
    logic [3:0] nonevent_prio;
    logic event_forced;
    logic nonevent_forced;
    logic [1:0] red_cp;
    logic [1:0] yellow_cp;
    logic [1:0] green_cp;
  } sqm_settings_t;

  typedef struct packed {
    logic is_ipv6;
    logic is_sync_event;
    logic is_sync_nonevent;
    logic [5:0] dscp;
    logic [7:0] next_hdr;
    logic [7:0] hop_next_hdr;
    logic is_igmp;
    logic [2:0] qos_prio;
    logic src_port_sel;
    logic dst_port_sel;
    logic port_mirror_on;
  } sqm_frame_t;

  typedef struct packed {
    logic to_host;
    logic mirror;
    logic dscp_hit;
    logic [3:0] queue_prio;
  } sqm_verdict_t;
endpackage

// >>> src/sqm_regs.sv
// Byte register storage with write masks
`timescale 1ns/1ns
`default_nettype none
`include "sqm_cfg.svh"
module sqm_regs (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  input wire logic [7:0] wmask,
  input wire logic [7:0] rst_val,
  output logic [7:0] value_q
);
  logic [7:0] value_d;

  always_comb begin
    value_d = value_q;
    if (wr_en) begin
      // Reserved bits keep their value
      value_d = (wdata & wmask) | (value_q & ~wmask);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      value_q <= rst_val;
    end else begin
      value_q <= value_d;
    end
  end
endmodule
`default_nettype wire

// >>> src/sqm_classify.sv
// Listener snoop packet classification
`timescale 1ns/1ns
`default_nettype none
`include "sqm_cfg.svh"
module sqm_classify (
  input wire logic criteria,
  input wire logic [7:0] next_hdr,
  input wire logic [7:0] hop_next_hdr,
  output logic is_listener
);
  function automatic logic nh_match(input logic crit, input logic [7:0] nh);
    if (crit) begin
      nh_match = nh == `SQM_NH_ROUTE || nh == `SQM_NH_FRAG ||
                 nh == `SQM_NH_ESP || nh == `SQM_NH_AUTH ||
                 nh == `SQM_NH_DSTOPT;
    end else begin
      nh_match = nh == `SQM_NH_ICMPV4 || nh == `SQM_NH_ICMPV6;
    end
  endfunction

  always_comb begin
    is_listener = nh_match(criteria, next_hdr) ||
                  (next_hdr == `SQM_NH_HOPBYHOP &&
                   nh_match(criteria, hop_next_hdr));
  end
endmodule
`default_nettype wire

// >>> src/sqm_top.sv
// Switch QoS, snoop and mirror global config bank with APB slave
`timescale 1ns/1ns
`default_nettype none
`include "sqm_cfg.svh"
module sqm_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire sqm_pkg::sqm_apb_req_t apb_req,
  output sqm_pkg::sqm_apb_rsp_t apb_rsp,
  input wire sqm_pkg::sqm_frame_t frame,
  output sqm_pkg::sqm_settings_t settings,
  output sqm_pkg::sqm_verdict_t verdict
);
  import sqm_pkg::*;

  localparam int NREG = 7;
  localparam logic [7:0] MIRSNP_RST = `SQM_MIRSNP_RST;
  localparam logic [7:0] COLOR_RST = `SQM_COLOR_RST;
  localparam logic [7:0] PRIO_RST = `SQM_PRIO_RST;
  // Settings leave reset already showing the register reset values
  localparam sqm_settings_t SET_RST = '{
    mirror_both_match: MIRSNP_RST[`SQM_BIT_MATCH],
    event_prio: PRIO_RST[3:0],
    nonevent_prio: PRIO_RST[3:0],
    event_forced: PRIO_RST[`SQM_BIT_OVR],
    nonevent_forced: PRIO_RST[`SQM_BIT_OVR],
    red_cp: COLOR_RST[5:4],
    yellow_cp: COLOR_RST[3:2],
    green_cp: COLOR_RST[1:0]
  };

  logic [7:0] reg_q [NREG];
  logic [7:0] wmask [NREG];
  logic [7:0] rstv [NREG];
  logic [11:0] idx [NREG];
  logic [NREG-1:0] hit;
  logic [NREG-1:0] wr;
  logic [9:0] word;
  logic access;
  logic listener;
  sqm_apb_rsp_t rsp_d;
  sqm_apb_rsp_t rsp_q;
  sqm_settings_t set_d;
  sqm_settings_t set_q;
  sqm_verdict_t ver_d;
  sqm_verdict_t ver_q;

  assign idx[0] = `SQM_IDX_MAP_3A;
  assign idx[1] = `SQM_IDX_MAP_3C;
  assign idx[2] = `SQM_IDX_MAP_3E;
  assign idx[3] = `SQM_IDX_MIRSNP;
  assign idx[4] = `SQM_IDX_COLOR;
  assign idx[5] = `SQM_IDX_EVT;
  assign idx[6] = `SQM_IDX_NEVT;
  assign wmask[0] = `SQM_MAP_WMASK;
  assign wmask[1] = `SQM_MAP_WMASK;
  assign wmask[2] = `SQM_MAP_WMASK;
  assign wmask[3] = `SQM_MIRSNP_WMASK;
  assign wmask[4] = `SQM_COLOR_WMASK;
  assign wmask[5] = `SQM_PRIO_WMASK;
  assign wmask[6] = `SQM_PRIO_WMASK;
  assign rstv[0] = `SQM_MAP_RST;
  assign rstv[1] = `SQM_MAP_RST;
  assign rstv[2] = `SQM_MAP_RST;
  assign rstv[3] = `SQM_MIRSNP_RST;
  assign rstv[4] = `SQM_COLOR_RST;
  assign rstv[5] = `SQM_PRIO_RST;
  assign rstv[6] = `SQM_PRIO_RST;

  // Printed offsets are indices; byte address is four times that
  assign word = apb_req.paddr[11:2];
  // Answer on the first access cycle unless already answered
  assign access = apb_req.psel && apb_req.penable && !rsp_q.pready;

  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_reg
      assign hit[g] = word == idx[g][9:0] && apb_req.paddr[1:0] == 2'h0 &&
                      idx[g][11:10] == 2'h0;
      // Write lands on the edge that completes the transfer
      assign wr[g] = apb_req.psel && apb_req.penable && rsp_q.pready &&
                     apb_req.pwrite && hit[g];
      sqm_regs u_reg (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_en(wr[g]),
        .wdata(apb_req.pwdata[7:0]),
        .wmask(wmask[g]),
        .rst_val(rstv[g]),
        .value_q(reg_q[g])
      );
    end
  endgenerate

  always_comb begin
    rsp_d = '0;
    if (access) begin
      rsp_d.pready = 1'b1;
      rsp_d.pslverr = hit == '0;
      for (int i = 0; i < NREG; i++) begin
        if (hit[i] && !apb_req.pwrite) begin
          // Upper lanes and reserved bits read zero
          rsp_d.prdata = {24'h000000, reg_q[i] & wmask[i]};
        end
      end
    end
  end

  sqm_classify u_cls (
    .criteria(reg_q[3][`SQM_BIT_CRIT]),
    .next_hdr(frame.next_hdr),
    .hop_next_hdr(frame.hop_next_hdr),
    .is_listener(listener)
  );

  always_comb begin
    set_d.mirror_both_match = reg_q[3][`SQM_BIT_MATCH];
    set_d.event_forced = reg_q[5][`SQM_BIT_OVR];
    set_d.event_prio = reg_q[5][3:0];
    set_d.nonevent_forced = reg_q[6][`SQM_BIT_OVR];
    set_d.nonevent_prio = reg_q[6][3:0];
    set_d.red_cp = reg_q[4][5:4];
    set_d.yellow_cp = reg_q[4][3:2];
    set_d.green_cp = reg_q[4][1:0];
  end

  always_comb begin
    ver_d = '0;
    ver_d.queue_prio = {1'b0, frame.qos_prio};
    // DSCP 3A..3F look up the top three map registers
    if (frame.dscp[5:3] == 3'h7 && frame.dscp[2:1] != 2'h0) begin
      ver_d.dscp_hit = 1'b1;
      if (frame.dscp[0]) begin
        ver_d.queue_prio = {1'b0, reg_q[frame.dscp[2:1] - 2'h1][6:4]};
      end else begin
        ver_d.queue_prio = {1'b0, reg_q[frame.dscp[2:1] - 2'h1][2:0]};
      end
    end
    if (frame.is_sync_event && reg_q[5][`SQM_BIT_OVR]) begin
      ver_d.queue_prio = reg_q[5][3:0];
    end
    if (frame.is_sync_nonevent && reg_q[6][`SQM_BIT_OVR]) begin
      ver_d.queue_prio = reg_q[6][3:0];
    end
    ver_d.to_host = (frame.is_igmp && !frame.is_ipv6 &&
                     reg_q[3][`SQM_BIT_V4SNOOP]) ||
                    (frame.is_ipv6 && listener &&
                     reg_q[3][`SQM_BIT_V6SNOOP]);
    // Mirroring needs the per-port enable too
    if (frame.port_mirror_on) begin
      if (reg_q[3][`SQM_BIT_MATCH]) begin
        ver_d.mirror = frame.src_port_sel && frame.dst_port_sel;
      end else begin
        ver_d.mirror = frame.src_port_sel || frame.dst_port_sel;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rsp_q <= '0;
      set_q <= SET_RST;
      ver_q <= '0;
    end else begin
      rsp_q <= rsp_d;
      set_q <= set_d;
      ver_q <= ver_d;
    end
  end

  // Registered answer: one wait state per access
  assign apb_rsp = rsp_q;
  assign settings = set_q;
  assign verdict = ver_q;
endmodule
`default_nettype wire

// >>> verif/sqm_asserts.sv
// Port checker for the switch config bank
`timescale 1ns/1ns
`default_nettype none
module sqm_asserts (
  input wire logic sys_clk,
  input wire logic rst,
  input wire sqm_pkg::sqm_apb_req_t apb_req,
  input wire sqm_pkg::sqm_apb_rsp_t apb_rsp,
  input wire sqm_pkg::sqm_frame_t frame,
  input wire sqm_pkg::sqm_settings_t settings,
  input wire sqm_pkg::sqm_verdict_t verdict
);
  import sqm_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_acc;
    apb_req.psel && apb_req.penable && !apb_rsp.pready;
  endsequence
  // Settings lag the register by one cycle, so skip cycles after a change
  property p_rd_zero;
    s_acc ##1 apb_rsp.pready |-> apb_rsp.prdata[31:8] == 24'h0;
  endproperty
  a_rd_zero: assert property (p_rd_zero)
    else $error("upper read bits set");
  property p_mir_off;
    !frame.port_mirror_on |=> !verdict.mirror;
  endproperty
  a_mir_off: assert property (p_mir_off)
    else $error("mirror while off");
  property p_mir_both;
    frame.port_mirror_on && frame.src_port_sel && frame.dst_port_sel
      |=> verdict.mirror;
  endproperty
  a_mir_both: assert property (p_mir_both)
    else $error("no mirror");
  property p_mir_one;
    frame.port_mirror_on && (frame.src_port_sel ^ frame.dst_port_sel)
      |=> !$stable(settings) || verdict.mirror != settings.mirror_both_match;
  endproperty
  a_mir_one: assert property (p_mir_one)
    else $error("mirror mode");
  property p_mir_nil;
    !frame.src_port_sel && !frame.dst_port_sel |=> !verdict.mirror;
  endproperty
  a_mir_nil: assert property (p_mir_nil)
    else $error("mirror no match");
  property p_evt;
    frame.is_sync_event && !frame.is_sync_nonevent |=> !$stable(settings) ||
      !settings.event_forced || verdict.queue_prio == settings.event_prio;
  endproperty
  a_evt: assert property (p_evt)
    else $error("event prio");
  property p_nevt;
    frame.is_sync_nonevent |=> !$stable(settings) ||
      !settings.nonevent_forced || verdict.queue_prio == settings.nonevent_prio;
  endproperty
  a_nevt: assert property (p_nevt)
    else $error("non-event prio");
  property p_color;
    $fell(rst) |-> settings.red_cp == 2'h3 && settings.yellow_cp == 2'h2 &&
      settings.green_cp == 2'h1;
  endproperty
  a_color: assert property (p_color)
    else $error("color reset");
endmodule
bind sqm_top sqm_asserts u_chk (.sys_clk(sys_clk), .rst(rst),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .frame(frame),
  .settings(settings), .verdict(verdict));
`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking bench for the switch config bank
`timescale 1ns/1ns
`default_nettype none
`include "sqm_cfg.svh"
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin bad_count++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module tb_top;
  import sqm_pkg::*;
  logic sys_clk = 0;
  logic rst = 1;
  sqm_apb_req_t apb_req = '0;
  sqm_apb_rsp_t apb_rsp;
  sqm_frame_t frame = '0;
  sqm_settings_t settings;
  sqm_verdict_t verdict;
  int bad_count = 0;
  int tests_run = 0;
  logic [7:0] regs [7];
  logic [11:0] idx [7] = '{`SQM_IDX_MAP_3A, `SQM_IDX_MAP_3C, `SQM_IDX_MAP_3E,
    `SQM_IDX_MIRSNP, `SQM_IDX_COLOR, `SQM_IDX_EVT, `SQM_IDX_NEVT};
  logic [7:0] msk [7] = '{8'h77, 8'h77, 8'h77, 8'h4D, 8'h3F, 8'h8F, 8'h8F};
  logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h39, 8'h0F, 8'h0F};
  logic [7:0] nh [9] = '{8'h00, 8'h01, 8'h3A, 8'h2B, 8'h2C, 8'h32, 8'h33,
    8'h3C, 8'h11};
  logic [31:0] r;
  logic e;
  sqm_frame_t f;
  sqm_verdict_t ev;
  sqm_top dut (.sys_clk(sys_clk), .rst(rst), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .frame(frame), .settings(settings), .verdict(verdict));
  initial forever #2 sys_clk = ~sys_clk;
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [7:0] d);
    int n;
    @(posedge sys_clk);
    apb_req <= '{a, 1'b1, 1'b0, w, {24'h0, d}};
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 16);
    r = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    if (n == 16) begin
      bad_count++;
      close_out();
    end
  endtask
  function automatic logic lsn(logic c, logic [7:0] h);
    return c ? h inside {8'h2B, 8'h2C, 8'h32, 8'h33, 8'h3C} :
      h inside {8'h01, 8'h3A};
  endfunction
  function automatic sqm_verdict_t exp_v(sqm_frame_t f);
    logic [7:0] m;
    logic [7:0] p;
    sqm_verdict_t v;
    m = regs[3];
    p = regs[f.dscp[2:1] - 2'd1];
    v.to_host = (m[6] && f.is_igmp && !f.is_ipv6) || (m[2] && f.is_ipv6 &&
      (lsn(m[3], f.next_hdr) || (f.next_hdr == 0 && lsn(m[3], f.hop_next_hdr))));
    v.mirror = f.port_mirror_on && (m[0] ? f.src_port_sel && f.dst_port_sel :
      f.src_port_sel || f.dst_port_sel);
    v.dscp_hit = f.dscp >= 6'h3A;
    v.queue_prio = v.dscp_hit ? {1'b0, f.dscp[0] ? p[6:4] : p[2:0]} :
      {1'b0, f.qos_prio};
    if (f.is_sync_event && regs[5][7]) v.queue_prio = regs[5][3:0];
    if (f.is_sync_nonevent && regs[6][7]) v.queue_prio = regs[6][3:0];
    return v;
  endfunction
  function automatic sqm_settings_t exp_s();
    return '{regs[3][0], regs[5][3:0], regs[6][3:0], regs[5][7], regs[6][7],
      regs[4][5:4], regs[4][3:2], regs[4][1:0]};
  endfunction
  task automatic rd_all;
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, {idx[i][9:0], 2'b00}, 8'h00);
      `CHK("reg", {24'h0, regs[i]}, r)
      `CHK("rd err", 1'b0, e)
    end
    `CHK("settings", exp_s(), settings)
  endtask
  initial begin
    repeat (100000) @(posedge sys_clk);
    bad_count++;
    close_out();
  end
  initial begin
    void'($urandom(32'h662A595F));
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    regs = rv;
    rd_all();
    apb(1'b1, 12'hD70, 8'hFF);
    `CHK("unmapped err", 1'b1, e)
    apb(1'b0, 12'hD75, 8'h00);
    `CHK("misaligned data", 32'h0, r)
    `CHK("misaligned err", 1'b1, e)
    for (int k = 0; k < 40; k++) begin
      for (int i = 0; i < 7; i++) begin
        regs[i] = (k == 0) ? 8'hFF : 8'($urandom);
        apb(1'b1, {idx[i][9:0], 2'b00}, regs[i]);
        regs[i] &= msk[i];
      end
      rd_all();
      for (int j = 0; j < 25; j++) begin
        f = $urandom;
        f.next_hdr = nh[$urandom % 9];
        f.hop_next_hdr = nh[$urandom % 9];
        if (j % 2) f.dscp[5:3] = 3'h7;
        @(posedge sys_clk);
        frame <= f;
        @(posedge sys_clk);
        @(negedge sys_clk);
        ev = exp_v(f);
        `CHK("to_host", ev.to_host, verdict.to_host)
        `CHK("mirror", ev.mirror, verdict.mirror)
        `CHK("dscp_hit", ev.dscp_hit, verdict.dscp_hit)
        `CHK("prio", ev.queue_prio, verdict.queue_prio)
      end
    end
    // Mid-run reset must bring every register back to its reset value
    @(posedge sys_clk);
    rst <= 1'b1;
    frame <= '0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    regs = rv;
    rd_all();
    close_out();
  end
endmodule
`default_nettype wire
